// >>> src/rtc_bus_port.sv
// real-time clock: asynchronous 4-bit host port, BCD time and calendar counters
// Operation
// - write captured on rising write strobe edge
// - drive data while selected and read low
// - read suppressed when read and write low
// - address passes while latch high, else held
// - low select gates latch; both selects gate read and write strobes
// - address chooses clock, calendar or control register
// - four-bit data, bit 0 least significant
// - open-drain pulse output ignores chip selects
// - timekeeping runs from 32.768 kHz base
// - every digit register holds one BCD digit
// - illegal written digits are not checked
// - 12-hour mode keeps hours-twenty as written
// - Gregorian calendar with automatic leap years
// - nonexistent date becomes next month's first
// - weekday counts 0 to 6, wrapping
// - missing bits ignored on write, read 0
// - hold blocks seconds tick; busy shows updates
// - carry during hold applied after release
`timescale 1ns/1ps
module rtc_bus_port (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic osc_in_i,
  input wire logic [3:0] addr_i,
  input wire logic latch_strobe_i,
  input wire logic low_active_select_n_i,
  input wire logic power_good_select_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [3:0] data_i,
  output logic [3:0] data_o,
  output logic data_oe_o,
  output logic timed_pulse_out_o,
  output logic timed_pulse_out_oe_o
);
  localparam int PIN_W = 14;
  // all pins asynchronous to core_clk_i
  logic [PIN_W-1:0] pin_s1, pin_s2;
  logic [1:0] edge_s3;
  always_ff @(posedge core_clk_i) begin
    pin_s1 <= {osc_in_i, wr_n_i, rd_n_i, low_active_select_n_i, power_good_select_i,
               latch_strobe_i, addr_i, data_i};
    pin_s2 <= pin_s1;
    edge_s3 <= pin_s2[13:12];
  end
  logic osc_s, wr_n_s, rd_n_s, cs_n_s, cs_s, ale_s;
  logic [3:0] addr_s, wdata_s;
  assign {osc_s, wr_n_s, rd_n_s, cs_n_s, cs_s, ale_s, addr_s, wdata_s} = pin_s2;
  logic osc_tick, wr_rise;
  assign osc_tick = osc_s & ~edge_s3[1];
  assign wr_rise = wr_n_s & ~edge_s3[0];

  function automatic logic [3:0] bit_mask(input logic [3:0] a);
    case (a)
      rtc_pkg::A_SEC10, rtc_pkg::A_MIN10, rtc_pkg::A_HR10, rtc_pkg::A_WEEK: bit_mask = 4'h7;
      rtc_pkg::A_DAY10: bit_mask = 4'h3;
      rtc_pkg::A_MON10: bit_mask = 4'h1;
      default: bit_mask = 4'hf;
    endcase
  endfunction
  function automatic logic [6:0] bin(input logic [3:0] t, input logic [3:0] o);
    bin = 7'(t) * 7'h0a + 7'(o);
  endfunction
  function automatic logic [6:0] month_days(input logic [6:0] m, input logic leap);
    case (m)
      7'd2: month_days = leap ? 7'd29 : 7'd28;
      7'd4, 7'd6, 7'd9, 7'd11: month_days = 7'd30;
      default: month_days = 7'd31;
    endcase
  endfunction

  logic [3:0] digit [rtc_pkg::DIGITS];
  logic [3:0] next_digit [rtc_pkg::DIGITS];
  logic [3:0] addr_hold, next_addr_hold, next_data, ctl_e, next_ctl_e;
  logic hold, next_hold, irq, next_irq, rest, next_rest, stop, next_stop;
  logic mode24, next_mode24, test, next_test, pending, next_pending, busy, next_busy;
  logic next_oe, next_pulse_oe;
  logic [rtc_pkg::PRESCALE_W-1:0] prescale, next_prescale;
  logic [8:0] pulse_cnt, next_pulse_cnt;
  logic [3:0] addr_eff, rd_val;
  logic run, sec_tick, fast_tick, sec_go, c_min, c_hr, c_day, c_mon, leap, evt, wr_evt;
  logic [6:0] hv, dv, mv;

  always_comb begin
    addr_eff = (ale_s & ~cs_n_s) ? addr_s : addr_hold;
    next_addr_hold = addr_eff;
    wr_evt = wr_rise & cs_s & ~cs_n_s;
    run = ~stop & ~rest;
    // stopping freezes the divider; reset clears the sub-second part
    next_prescale = rest ? '0 : prescale + {{(rtc_pkg::PRESCALE_W-1){1'b0}}, osc_tick & run};
    sec_tick = osc_tick & run & (&prescale);
    fast_tick = osc_tick & run & (&prescale[rtc_pkg::FAST_W-1:0]);
    sec_go = (sec_tick | pending) & ~hold;
    next_pending = hold & (pending | sec_tick);
    next_busy = sec_go;
    next_digit = digit;
    {c_min, c_hr, c_day, c_mon} = 4'h0;
    hv = bin({2'b00, digit[rtc_pkg::A_HR10][1:0]}, digit[rtc_pkg::A_HR1]);
    dv = bin(digit[rtc_pkg::A_DAY10], digit[rtc_pkg::A_DAY1]);
    mv = bin(digit[rtc_pkg::A_MON10], digit[rtc_pkg::A_MON1]);
    // two-digit year divisible by four; tens parity decides which ones qualify
    leap = digit[rtc_pkg::A_YR10][0] ? (digit[rtc_pkg::A_YR1] == 4'h2 ||
           digit[rtc_pkg::A_YR1] == 4'h6) : (digit[rtc_pkg::A_YR1][1:0] == 2'b00);
    if (sec_go) begin
      next_digit[0] = (digit[0] >= 4'h9) ? 4'h0 : digit[0] + 4'h1;
      if (digit[0] >= 4'h9) begin
        next_digit[1] = (digit[1] >= 4'h5) ? 4'h0 : digit[1] + 4'h1;
        c_min = digit[1] >= 4'h5;
      end
    end
    if (c_min) begin
      next_digit[2] = (digit[2] >= 4'h9) ? 4'h0 : digit[2] + 4'h1;
      if (digit[2] >= 4'h9) begin
        next_digit[3] = (digit[3] >= 4'h5) ? 4'h0 : digit[3] + 4'h1;
        c_hr = digit[3] >= 4'h5;
      end
    end
    if (c_hr) begin
      if (mode24 && hv >= 7'd23) begin
        next_digit[4] = 4'h0;
        next_digit[5] = 4'h0;
        c_day = 1'b1;
      end else if (!mode24 && hv == 7'd11) begin
        // 11 to 12 flips the afternoon flag; the day turns at midnight
        next_digit[4] = 4'h2;
        next_digit[5] = {1'b0, ~digit[5][rtc_pkg::HR_PM], 2'b01};
        c_day = digit[5][rtc_pkg::HR_PM];
      end else if (!mode24 && hv >= 7'd12) begin
        next_digit[4] = 4'h1;
        next_digit[5] = {1'b0, digit[5][rtc_pkg::HR_PM], 2'b00};
      end else if (digit[4] >= 4'h9) begin
        next_digit[4] = 4'h0;
        next_digit[5] = digit[5] + 4'h1;
      end else begin
        next_digit[4] = digit[4] + 4'h1;
      end
    end
    if (c_day) begin
      next_digit[rtc_pkg::A_WEEK] = (digit[rtc_pkg::A_WEEK] >= rtc_pkg::WEEK_LAST) ? 4'h0 :
                                    digit[rtc_pkg::A_WEEK] + 4'h1;
      if (dv >= month_days(mv, leap)) begin
        next_digit[6] = 4'h1;
        next_digit[7] = 4'h0;
        c_mon = 1'b1;
      end else if (digit[6] >= 4'h9) begin
        next_digit[6] = 4'h0;
        next_digit[7] = digit[7] + 4'h1;
      end else begin
        next_digit[6] = digit[6] + 4'h1;
      end
    end
    if (c_mon) begin
      if (mv >= 7'd12) begin
        next_digit[8] = 4'h1;
        next_digit[9] = 4'h0;
        next_digit[10] = (digit[10] >= 4'h9) ? 4'h0 : digit[10] + 4'h1;
        if (digit[10] >= 4'h9) begin
          next_digit[11] = (digit[11] >= 4'h9) ? 4'h0 : digit[11] + 4'h1;
        end
      end else if (digit[8] >= 4'h9) begin
        next_digit[8] = 4'h0;
        next_digit[9] = 4'h1;
      end else begin
        next_digit[8] = digit[8] + 4'h1;
      end
    end
    {next_hold, next_rest, next_stop, next_mode24, next_test} = {hold, rest, stop, mode24, test};
    next_ctl_e = ctl_e;
    // a host write lands after the carry so it always wins its digit
    if (wr_evt) begin
      if (addr_eff < rtc_pkg::A_CTL_D) begin
        next_digit[addr_eff] = wdata_s & bit_mask(addr_eff);
        if (addr_eff == rtc_pkg::A_HR10 && mode24) begin
          next_digit[addr_eff][rtc_pkg::HR_PM] = 1'b0;
        end
      end else if (addr_eff == rtc_pkg::A_CTL_D) begin
        next_hold = wdata_s[rtc_pkg::D_HOLD];
      end else if (addr_eff == rtc_pkg::A_CTL_E) begin
        next_ctl_e = wdata_s;
      end else begin
        next_rest = wdata_s[rtc_pkg::F_REST];
        next_stop = wdata_s[rtc_pkg::F_STOP];
        next_test = wdata_s[rtc_pkg::F_TEST];
        if (rest) begin
          next_mode24 = wdata_s[rtc_pkg::F_MODE24];
        end
      end
    end
    // losing power-good drops hold and reset
    next_hold = next_hold & cs_s;
    next_rest = next_rest & cs_s;
    case (ctl_e[3:2])
      2'b00: evt = fast_tick;
      2'b01: evt = sec_go;
      2'b10: evt = c_min;
      2'b11: evt = c_hr;
      default: evt = 1'b0;
    endcase
    next_irq = irq & ~(wr_evt && addr_eff == rtc_pkg::A_CTL_D && !wdata_s[rtc_pkg::D_IRQ]);
    next_pulse_cnt = pulse_cnt;
    if (irq && !ctl_e[rtc_pkg::E_ITRPT] && osc_tick) begin
      next_pulse_cnt = pulse_cnt - 9'h001;
      if (pulse_cnt == 9'h001) begin
        next_irq = 1'b0;
      end
    end
    // a new event while the flag stands is ignored, even in the cycle that clears the flag
    if (evt && !irq) begin
      next_irq = 1'b1;
      next_pulse_cnt = 9'(rtc_pkg::PULSE_LOW_OSC);
    end
    case (addr_eff)
      rtc_pkg::A_CTL_D: rd_val = {1'b0, irq, busy, hold};
      rtc_pkg::A_CTL_E: rd_val = ctl_e;
      rtc_pkg::A_CTL_F: rd_val = {test, mode24, stop, rest};
      rtc_pkg::A_HR10: rd_val = mode24 ? (digit[addr_eff] & 4'h3) : digit[addr_eff];
      default: rd_val = digit[addr_eff];
    endcase
    next_oe = cs_s & ~cs_n_s & ~rd_n_s & wr_n_s;
    next_data = next_oe ? rd_val : 4'h0;
    next_pulse_oe = next_irq & ~next_ctl_e[rtc_pkg::E_MASK];
  end

  always_ff @(posedge core_clk_i) begin
    timed_pulse_out_o <= 1'b0; // open drain: the pin is only ever pulled low
    if (!rstn_i) begin
      digit <= '{default: 4'h0};
      addr_hold <= 4'h0;
      ctl_e <= 4'h0;
      hold <= 1'b0;
      irq <= 1'b0;
      rest <= 1'b0;
      stop <= 1'b0;
      mode24 <= 1'b0;
      test <= 1'b0;
      pending <= 1'b0;
      busy <= 1'b0;
      prescale <= '0;
      pulse_cnt <= 9'h000;
      data_o <= 4'h0;
      data_oe_o <= 1'b0;
      timed_pulse_out_oe_o <= 1'b0;
    end else begin
      digit <= next_digit;
      addr_hold <= next_addr_hold;
      ctl_e <= next_ctl_e;
      hold <= next_hold;
      irq <= next_irq;
      rest <= next_rest;
      stop <= next_stop;
      mode24 <= next_mode24;
      test <= next_test;
      pending <= next_pending;
      busy <= next_busy;
      prescale <= next_prescale;
      pulse_cnt <= next_pulse_cnt;
      data_o <= next_data;
      data_oe_o <= next_oe;
      timed_pulse_out_oe_o <= next_pulse_oe;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  rd_wr_clash_a: assert property (!rd_n_s && !wr_n_s |=> !data_oe_o)
    else $error("read driven during write clash");
  read_drive_a: assert property (cs_s && !cs_n_s && !rd_n_s && wr_n_s |=> data_oe_o)
    else $error("selected read not driven");
  deselect_quiet_a: assert property (!cs_s |=> !data_oe_o)
    else $error("data driven while deselected");
  sec_write_a: assert property (wr_evt && addr_eff == 4'h0 |=> digit[0] == $past(wdata_s))
    else $error("seconds write not captured");
  tens_sec_bit_a: assert property (digit[1][3] == 1'b0 && digit[9][3:1] == 3'b000)
    else $error("missing bit stored");
  week_wrap_a: assert property (c_day && digit[12] == 4'h6 && !wr_evt |=> digit[12] == 4'h0)
    else $error("weekday did not wrap");
  hold_block_a: assert property (hold && sec_tick |=> pending)
    else $error("held carry lost");
  pending_apply_a: assert property (pending && !hold |-> sec_go ##1 !pending)
    else $error("held carry not applied");
  sec_divide_a: assert property (sec_tick |-> prescale == 15'h7fff)
    else $error("seconds tick off divider");
  pm_read_a: assert property (next_oe && mode24 && addr_eff == 4'h5 |=> !data_o[2])
    else $error("afternoon flag read in 24h mode");
  pulse_mask_a: assert property (timed_pulse_out_oe_o |-> irq && !ctl_e[0])
    else $error("pulse driven while masked");
  day_roll_c: cover property (c_mon && !wr_evt);
  hold_carry_c: cover property (pending ##1 !hold);
  read_c: cover property (data_oe_o ##1 !data_oe_o);
endmodule // rtc_bus_port

// >>> src/rtc_pkg.sv
// constants for the real-time clock bus port and calendar
package rtc_pkg;
  localparam int DATA_W = 4;
  localparam int ADDR_W = 4;
  localparam int DIGITS = 13;
  localparam int PRESCALE_W = 15;
  localparam int FAST_W = 9;
  localparam int OSC_HZ = 32768;
  localparam longint PULSE_LOW_NS = 64'd7812500;
  localparam int PULSE_LOW_OSC = int'((PULSE_LOW_NS * OSC_HZ) / 64'd1000000000);
  localparam logic [3:0] A_SEC1 = 4'h0;
  localparam logic [3:0] A_SEC10 = 4'h1;
  localparam logic [3:0] A_MIN1 = 4'h2;
  localparam logic [3:0] A_MIN10 = 4'h3;
  localparam logic [3:0] A_HR1 = 4'h4;
  localparam logic [3:0] A_HR10 = 4'h5;
  localparam logic [3:0] A_DAY1 = 4'h6;
  localparam logic [3:0] A_DAY10 = 4'h7;
  localparam logic [3:0] A_MON1 = 4'h8;
  localparam logic [3:0] A_MON10 = 4'h9;
  localparam logic [3:0] A_YR1 = 4'ha;
  localparam logic [3:0] A_YR10 = 4'hb;
  localparam logic [3:0] A_WEEK = 4'hc;
  localparam logic [3:0] A_CTL_D = 4'hd;
  localparam logic [3:0] A_CTL_E = 4'he;
  localparam logic [3:0] A_CTL_F = 4'hf;
  localparam int D_HOLD = 0;
  localparam int D_BUSY = 1;
  localparam int D_IRQ = 2;
  localparam int E_MASK = 0;
  localparam int E_ITRPT = 1;
  localparam int F_REST = 0;
  localparam int F_STOP = 1;
  localparam int F_MODE24 = 2;
  localparam int F_TEST = 3;
  localparam int HR_PM = 2;
  localparam logic [3:0] WEEK_LAST = 4'h6;
endpackage

// >>> testbench/host_bus_model.sv
// host bus model: strobes, selects and latch as a controller drives them
`timescale 1ns/1ps
module host_bus_model (
  input wire logic core_clk_i,
  input wire logic [3:0] data_i,
  input wire logic data_oe_i,
  output logic [3:0] addr_o,
  output logic latch_o,
  output logic sel_n_o,
  output logic pg_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [3:0] data_o
);
  initial begin
    addr_o = 4'h0;
    latch_o = 1'b1; // latch starts high so the address passes through
    sel_n_o = 1'b0;
    pg_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = 4'h0;
  end
  // select setup is long, 100 cycles covers it
  task automatic set_pins(input logic pg, input logic sn, input logic le);
    @(posedge core_clk_i);
    #1;
    pg_o = pg;
    sel_n_o = sn;
    latch_o = le;
    repeat (100) @(posedge core_clk_i);
  endtask
  // strobe held 6 cycles, twice the minimum, then recovery
  task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [3:0] d,
                     output logic [3:0] q, output logic oe);
    @(posedge core_clk_i);
    #1;
    addr_o = a;
    data_o = d;
    rd_n_o = !r;
    wr_n_o = !w;
    repeat (6) @(posedge core_clk_i);
    #1;
    q = data_i;
    oe = data_oe_i;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    repeat (6) @(posedge core_clk_i);
    #1;
    data_o = ~d; // released lines must not keep the old value
  endtask
endmodule // host_bus_model

// >>> testbench/tb_rtc_bus_port.sv
// self-checking bench for the clock host port and calendar
`timescale 1ns/1ps
module tb_rtc_bus_port;
  logic clk;
  logic rstn;
  logic osc;
  int osc_left;
  int miscompares;
  int num_checks;
  logic [3:0] addr, hd, dq, bus, q;
  logic le, sn, pg, rd_n, wr_n, doe, oe;
  logic tpo, tpoe;
  logic [3:0] mem [13];
  localparam logic [3:0] set_tv [13] = '{4'h9, 4'h5, 4'h9, 4'h5, 4'h3, 4'h2, 4'h8,
    4'h2, 4'h2, 4'h0, 4'h0, 4'h0, 4'h6};
  localparam logic [3:0] exp_tv [13] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h9,
    4'h2, 4'h2, 4'h0, 4'h0, 4'h0, 4'h0};
  assign bus = doe ? dq : hd;
  rtc_bus_port u_rtc_bus_port (.core_clk_i(clk), .rstn_i(rstn), .osc_in_i(osc),
    .addr_i(addr), .latch_strobe_i(le), .low_active_select_n_i(sn),
    .power_good_select_i(pg), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(bus), .data_o(dq),
    .data_oe_o(doe), .timed_pulse_out_o(tpo), .timed_pulse_out_oe_o(tpoe));
  host_bus_model u_host_bus_model (.core_clk_i(clk), .data_i(bus), .data_oe_i(doe),
    .addr_o(addr), .latch_o(le), .sel_n_o(sn), .pg_o(pg), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .data_o(hd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // time base toggled every core cycle: fastest the synchroniser can follow
  always @(posedge clk) begin
    #1;
    if (osc_left > 0) begin
      osc = ~osc;
      if (osc) osc_left = osc_left - 1;
    end
  end
  function automatic logic [3:0] fmask(input int a, input logic h24);
    case (a)
      1, 3, 12: return 4'h7;
      5: return h24 ? 4'h3 : 4'h7;
      7: return 4'h3;
      9: return 4'h1;
      default: return 4'hf;
    endcase
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] d);
    logic [3:0] x;
    logic o;
    u_host_bus_model.cyc(1'b1, 1'b0, a, d, x, o);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [3:0] e);
    u_host_bus_model.cyc(1'b0, 1'b1, a, 4'h0, q, oe);
    chk({3'h0, oe}, 4'h1);
    chk(q, e);
  endtask
  task automatic chk_pulse(input logic e);
    chk({2'h0, tpo, tpoe}, {3'h0, e});
  endtask
  // bounded wait for n rising time-base edges; a run that stalls counts as a mismatch
  task automatic run_osc(input int n);
    osc_left = n;
    for (int i = 0; i < 3 * n && osc_left > 0; i++) @(posedge clk);
    if (osc_left > 0) begin
      miscompares++;
      $display("[FAIL] t=%0t osc edges left %h exp %h", $time, osc_left, 0);
    end
    repeat (10) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    osc = 1'b0;
    osc_left = 0;
    miscompares = 0;
    num_checks = 0;
    void'($urandom(80737));
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 13; a++) begin
        if (p == 0) rdc(4'(a), 4'h0);
        mem[a] = (p != 0) ? 4'($urandom) : 4'hf;
        wr(4'(a), mem[a]);
        mem[a] &= fmask(a, 1'b0);
        rdc(4'(a), mem[a]);
      end
    end
    $display("test registers done");
    u_host_bus_model.cyc(1'b1, 1'b1, 4'h4, 4'h2, q, oe);
    chk({3'h0, oe}, 4'h0);
    u_host_bus_model.set_pins(1'b0, 1'b0, 1'b1);
    u_host_bus_model.cyc(1'b0, 1'b1, 4'h0, 4'h0, q, oe);
    chk({3'h0, oe}, 4'h0);
    u_host_bus_model.set_pins(1'b1, 1'b1, 1'b1);
    wr(4'h2, ~mem[2]);
    u_host_bus_model.set_pins(1'b1, 1'b0, 1'b1);
    rdc(4'h2, mem[2]);
    rdc(4'h3, mem[3]);
    u_host_bus_model.set_pins(1'b1, 1'b0, 1'b0);
    rdc(4'h8, mem[3]);
    u_host_bus_model.set_pins(1'b1, 1'b0, 1'b1);
    $display("test strobes done");
    wr(4'hf, 4'h1);
    wr(4'hf, 4'h5);
    wr(4'hf, 4'h4);
    rdc(4'hf, 4'h4);
    wr(4'h5, 4'h6);
    rdc(4'h5, 4'h2 & fmask(5, 1'b1));
    for (int a = 0; a < 13; a++) wr(4'(a), set_tv[a]);
    run_osc(32768 + 8);
    for (int a = 0; a < 13; a++) rdc(4'(a), exp_tv[a]);
    $display("test calendar done");
    // interrupt mode at 1/64 s, hold set so the seconds stay put
    wr(4'he, 4'h2);
    wr(4'hd, 4'h1);
    chk_pulse(1'b0);
    rdc(4'hd, 4'h1);
    run_osc(520);
    chk_pulse(1'b1);
    rdc(4'hd, 4'h5);
    wr(4'he, 4'h3);
    chk_pulse(1'b0);
    wr(4'hd, 4'h0);
    rdc(4'hd, 4'h0);
    $display("test pulse done");
    print_verdict();
  end
endmodule // tb_rtc_bus_port
